// [include/stsr_pkg.sv]
// constants and carrier types of the threshold-sector and return-status responder
package stsr_pkg;
	// command decode
	localparam logic [7:0] STSR_CMD_MONITOR = 8'hB0;
	localparam logic [7:0] STSR_FEAT_READ_THR = 8'hD1;
	localparam logic [7:0] STSR_FEAT_RET_STATUS = 8'hDA;
	localparam logic [7:0] STSR_KEY_CYL_LO = 8'h4F;
	localparam logic [7:0] STSR_KEY_CYL_HI = 8'hC2;
	// return-status signatures
	localparam logic [7:0] STSR_OK_CYL_LO = 8'h4F;
	localparam logic [7:0] STSR_OK_CYL_HI = 8'hC2;
	localparam logic [7:0] STSR_BAD_CYL_LO = 8'hF4;
	localparam logic [7:0] STSR_BAD_CYL_HI = 8'h2C;
	// sector layout
	localparam logic [15:0] STSR_VERSION = 16'h0004;
	localparam logic [8:0] STSR_ENTRY_START = 9'h002;
	localparam logic [8:0] STSR_ENTRY_END = 9'h16A;
	localparam logic [8:0] STSR_CSUM_IDX = 9'h1FF;
	localparam logic [3:0] STSR_ENTRY_LAST_POS = 4'hB;
	localparam logic [4:0] STSR_ENTRY_USED = 5'h06;
	// attribute identifiers, in entry order
	localparam logic [7:0] STSR_ID_SPARE = 8'hC4;
	localparam logic [7:0] STSR_ID_ERASE = 8'hE5;
	localparam logic [7:0] STSR_ID_ECC_TOTAL = 8'hCB;
	localparam logic [7:0] STSR_ID_ECC_CORR = 8'hCC;
	localparam logic [7:0] STSR_ID_READS = 8'hE8;
	localparam logic [7:0] STSR_ID_UDMA_CRC = 8'hC7;
	// reset values
	localparam logic [8:0] STSR_IDX_RST = 9'h000;
	localparam logic [7:0] STSR_BYTE_RST = 8'h00;

	// task-file command as presented by the register front end
	typedef struct packed {
		logic [7:0] command;
		logic [7:0] features;
		logic [7:0] cyl_hi;
		logic [7:0] cyl_lo;
	} stsr_cmd_t;

	// monitored attribute values and their thresholds
	typedef struct packed {
		logic [7:0] spare_thr;
		logic [7:0] erase_thr;
		logic [7:0] spare_val;
		logic [7:0] erase_val;
	} stsr_attr_t;

	typedef enum logic [1:0] {
		STSR_IDLE,
		STSR_SEND
	} stsr_state_t;
endpackage

// [rtl/stsr_responder.sv]
// threshold-sector builder and return-status responder for the monitoring command
// What this block does
// R1 - sector is 512 bytes: version 0004h, thirty 12-byte entries, checksum at byte 511.
// R2 - spare-block entry: id C4h, spare threshold, then ten zero bytes.
// R3 - erase-count entry: id E5h, erase threshold, then ten zero bytes.
// R4 - total ECC entry: id CBh, zero threshold, ten zero bytes.
// R5 - corrected ECC entry: id CCh, zero threshold, ten zero bytes.
// R6 - read-count entry: id E8h, zero threshold, ten zero bytes.
// R7 - UDMA CRC entry: id C7h, zero threshold, ten zero bytes.
// R8 - return status with a crossed threshold loads F4h low and 2Ch high.
// R9 - return status with no crossed threshold loads 4Fh low and C2h high.
// R10 - host asks for the sector with features D1h and cylinder C2h/4Fh.
// R11 - spare attribute is exceeded when its value is below its threshold.
// R12 - erase attribute is exceeded when its value is below its threshold.
// R13 - checksum is two's complement of the first 511 bytes' sum.
`timescale 1ns/1ps
`default_nettype none
module stsr_responder
	import stsr_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// command from task-file front end
	input wire logic cmd_valid_i,
	input wire stsr_cmd_t cmd_i,
	output logic cmd_ready_o,
	output logic cmd_abort_o,
	// attribute values and thresholds
	input wire stsr_attr_t attr_i,
	output logic exceeded_o,
	// sector byte stream toward the data port
	output logic sec_valid_o,
	input wire logic sec_ready_i,
	output logic [7:0] sec_data_o,
	output logic sec_last_o,
	output logic sec_done_o,
	// return-status result for the cylinder registers
	output logic cyl_load_o,
	output logic [7:0] cyl_lo_o,
	output logic [7:0] cyl_hi_o
);

	stsr_state_t state_q;
	logic [8:0] idx_q;
	logic [8:0] idx_d;
	logic [4:0] ent_q;
	logic [4:0] ent_d;
	logic [3:0] pos_q;
	logic [3:0] pos_d;
	logic [7:0] data_q;
	logic [7:0] sum_q;
	logic last_q;
	logic [7:0] spare_thr_q;
	logic [7:0] erase_thr_q;
	logic abort_q;
	logic done_q;
	logic load_q;
	logic [7:0] cyl_lo_q;
	logic [7:0] cyl_hi_q;
	logic accept;
	logic is_monitor;
	logic want_sector;
	logic want_status;
	logic beat;
	logic exceeded;

	// identifier of an entry slot; unused slots read as zero
	function automatic logic [7:0] entry_id(input logic [4:0] ent);
		case (ent)
			5'h00: entry_id = STSR_ID_SPARE; // [R2]
			5'h01: entry_id = STSR_ID_ERASE; // [R3]
			5'h02: entry_id = STSR_ID_ECC_TOTAL; // [R4]
			5'h03: entry_id = STSR_ID_ECC_CORR; // [R5]
			5'h04: entry_id = STSR_ID_READS; // [R6]
			5'h05: entry_id = STSR_ID_UDMA_CRC; // [R7]
			default: entry_id = STSR_BYTE_RST;
		endcase
	endfunction

	// one byte of the sector below the checksum position
	function automatic logic [7:0] sector_byte(
		input logic [8:0] idx,
		input logic [4:0] ent,
		input logic [3:0] pos,
		input logic [7:0] spare_thr,
		input logic [7:0] erase_thr
	);
		sector_byte = STSR_BYTE_RST;
		if (idx < STSR_ENTRY_START)
		begin
			// version word, low byte first
			sector_byte = idx[0] ? STSR_VERSION[15:8] : STSR_VERSION[7:0]; // [R1]
		end
		else if (idx < STSR_ENTRY_END && ent < STSR_ENTRY_USED)
		begin
			if (pos == 4'h0)
				sector_byte = entry_id(ent);
			else if (pos == 4'h1 && ent == 5'h00)
				sector_byte = spare_thr; // [R2]
			else if (pos == 4'h1 && ent == 5'h01)
				sector_byte = erase_thr; // [R3]
		end
	endfunction

	// command decode; only the idle state takes a command
	assign cmd_ready_o = (state_q == STSR_IDLE);
	assign accept = cmd_valid_i && cmd_ready_o;
	assign is_monitor = (cmd_i.command == STSR_CMD_MONITOR);
	// sector is only returned for the fixed cylinder key, anything else is aborted
	assign want_sector = is_monitor && cmd_i.features == STSR_FEAT_READ_THR
		&& cmd_i.cyl_hi == STSR_KEY_CYL_HI && cmd_i.cyl_lo == STSR_KEY_CYL_LO; // [R10]
	assign want_status = is_monitor && cmd_i.features == STSR_FEAT_RET_STATUS;
	assign beat = sec_valid_o && sec_ready_i;

	// live comparison of the two monitored attributes
	assign exceeded = (attr_i.spare_val < attr_i.spare_thr) // [R11]
		|| (attr_i.erase_val < attr_i.erase_thr); // [R12]
	assign exceeded_o = exceeded;

	// next byte position; entry counters run from the first entry byte to the end of the sector
	always_comb
	begin
		idx_d = idx_q + 9'h001;
		ent_d = ent_q;
		pos_d = pos_q;
		if (idx_q >= STSR_ENTRY_START)
		begin
			if (pos_q == STSR_ENTRY_LAST_POS)
			begin
				pos_d = 4'h0;
				ent_d = ent_q + 5'h01;
			end
			else
				pos_d = pos_q + 4'h1;
		end
	end

	// sequencer
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			state_q <= STSR_IDLE;
		else if (accept && want_sector)
			state_q <= STSR_SEND;
		else if (beat && last_q)
			state_q <= STSR_IDLE;
	end

	// byte counters, staged byte and running sum
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			idx_q <= STSR_IDX_RST;
			ent_q <= 5'h00;
			pos_q <= 4'h0;
			data_q <= STSR_BYTE_RST;
			sum_q <= STSR_BYTE_RST;
			last_q <= 1'b0;
		end
		else if (accept && want_sector)
		begin
			idx_q <= STSR_IDX_RST;
			ent_q <= 5'h00;
			pos_q <= 4'h0;
			data_q <= STSR_VERSION[7:0]; // [R1]
			sum_q <= STSR_BYTE_RST;
			last_q <= 1'b0;
		end
		else if (beat && !last_q)
		begin
			idx_q <= idx_d;
			ent_q <= ent_d;
			pos_q <= pos_d;
			sum_q <= sum_q + data_q;
			last_q <= (idx_d == STSR_CSUM_IDX); // [R1]
			// closing byte makes all 512 bytes sum to zero
			if (idx_d == STSR_CSUM_IDX)
				data_q <= 8'h00 - (sum_q + data_q); // [R13]
			else
				data_q <= sector_byte(idx_d, ent_d, pos_d, spare_thr_q, erase_thr_q);
		end
	end

	// thresholds frozen per sector so a mid-transfer change cannot break the checksum
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			spare_thr_q <= STSR_BYTE_RST;
			erase_thr_q <= STSR_BYTE_RST;
		end
		else if (accept && want_sector)
		begin
			spare_thr_q <= attr_i.spare_thr;
			erase_thr_q <= attr_i.erase_thr;
		end
	end

	// return-status signature for the cylinder registers
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			load_q <= 1'b0;
			cyl_lo_q <= STSR_BYTE_RST;
			cyl_hi_q <= STSR_BYTE_RST;
		end
		else
		begin
			load_q <= accept && want_status;
			if (accept && want_status)
			begin
				cyl_lo_q <= exceeded ? STSR_BAD_CYL_LO : STSR_OK_CYL_LO; // [R8] [R9]
				cyl_hi_q <= exceeded ? STSR_BAD_CYL_HI : STSR_OK_CYL_HI; // [R8] [R9]
			end
		end
	end

	// completion and refusal pulses
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			abort_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			abort_q <= accept && !want_sector && !want_status;
			done_q <= beat && last_q;
		end
	end

	assign sec_valid_o = (state_q == STSR_SEND);
	assign sec_data_o = data_q;
	assign sec_last_o = last_q;
	assign sec_done_o = done_q;
	assign cmd_abort_o = abort_q;
	assign cyl_load_o = load_q;
	assign cyl_lo_o = cyl_lo_q;
	assign cyl_hi_o = cyl_hi_q;

endmodule
`default_nettype wire

// [verif/stsr_host_model.sv]
// sink side of the sector stream, optionally slow
`timescale 1ns/1ps
`default_nettype none
module stsr_host_model (
	// clock and pacing request
	input wire logic ref_clk_i,
	input wire logic stall_i,
	// byte accept toward the responder
	output logic sec_ready_o
);
	logic [1:0] cnt_q = 2'h0;
	// free pacing count; a slow sink takes one byte in four
	always_ff @(posedge ref_clk_i)
		cnt_q <= cnt_q + 2'h1;
	assign sec_ready_o = !stall_i || cnt_q == 2'h3;
endmodule
`default_nettype wire

// [verif/stsr_responder_assertions.sv]
// port checks for the responder
`timescale 1ns/1ps
`default_nettype none
module stsr_responder_chk
	import stsr_pkg::*;
(
	// clock, reset and command
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic cmd_valid_i,
	input wire stsr_cmd_t cmd_i,
	input wire logic cmd_ready_o,
	input wire logic cmd_abort_o,
	// attributes and stream
	input wire stsr_attr_t attr_i,
	input wire logic exceeded_o,
	input wire logic sec_valid_o,
	input wire logic sec_ready_i,
	input wire logic [7:0] sec_data_o,
	input wire logic sec_last_o,
	input wire logic sec_done_o,
	// status result
	input wire logic cyl_load_o,
	input wire logic [7:0] cyl_lo_o,
	input wire logic [7:0] cyl_hi_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	// taken status and sector requests
	wire logic tk = cmd_valid_i && cmd_ready_o;
	wire logic st = tk && cmd_i[31:16] == {STSR_CMD_MONITOR, STSR_FEAT_RET_STATUS};
	wire logic rd = tk && cmd_i == {STSR_CMD_MONITOR, STSR_FEAT_READ_THR, STSR_KEY_CYL_HI, STSR_KEY_CYL_LO};
	a_status_ok: assert property (st && !exceeded_o |=> cyl_load_o && {cyl_hi_o, cyl_lo_o} == 16'hC24F)
		else $error("clean signature wrong");
	a_status_bad: assert property (st && exceeded_o |=> cyl_load_o && {cyl_hi_o, cyl_lo_o} == 16'h2CF4)
		else $error("crossed signature wrong");
	a_spare_low: assert property (attr_i.spare_val < attr_i.spare_thr |-> exceeded_o)
		else $error("spare crossing missed");
	a_erase_low: assert property (attr_i.erase_val < attr_i.erase_thr |-> exceeded_o)
		else $error("erase crossing missed");
	a_none_low: assert property (exceeded_o |-> attr_i.spare_val < attr_i.spare_thr || attr_i.erase_val < attr_i.erase_thr)
		else $error("false crossing");
	a_sector_start: assert property (rd |=> sec_valid_o && sec_data_o == 8'h04)
		else $error("sector start wrong");
	a_byte_hold: assert property (sec_valid_o && !sec_ready_i |=> sec_valid_o && $stable(sec_data_o))
		else $error("byte moved in stall");
	a_last_done: assert property (sec_valid_o && sec_ready_i && sec_last_o |=> sec_done_o && !sec_valid_o)
		else $error("sector end wrong");
	c_status: cover property (st ##1 cyl_load_o);
	c_stall: cover property (sec_valid_o && !sec_ready_i);
	c_done: cover property (sec_done_o);
endmodule
bind stsr_responder stsr_responder_chk i_chk (.ref_clk_i, .srst_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .cmd_abort_o,
	.attr_i, .exceeded_o, .sec_valid_o, .sec_ready_i, .sec_data_o, .sec_last_o, .sec_done_o, .cyl_load_o, .cyl_lo_o, .cyl_hi_o);
`default_nettype wire

// [verif/tb.sv]
// bench for the threshold sector and return status
`timescale 1ns/1ps
`default_nettype none
module tb;
	import stsr_pkg::*;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	logic stall = 1'b0;
	stsr_cmd_t cmd_i = '0;
	stsr_attr_t attr_i = '0;
	logic cmd_ready_o, cmd_abort_o, exceeded_o, sec_valid_o, sec_ready_i, sec_last_o, sec_done_o, cyl_load_o;
	logic [7:0] sec_data_o, cyl_lo_o, cyl_hi_o;
	int n_errors = 0;
	int num_checks = 0;
	// 125 MHz clock
	always #4 ref_clk_i = ~ref_clk_i;
	stsr_responder i_dut (.ref_clk_i, .srst_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .cmd_abort_o, .attr_i, .exceeded_o,
		.sec_valid_o, .sec_ready_i, .sec_data_o, .sec_last_o, .sec_done_o, .cyl_load_o, .cyl_lo_o, .cyl_hi_o);
	stsr_host_model i_host (.ref_clk_i, .stall_i(stall), .sec_ready_o(sec_ready_i));
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// a spent wait bound ends the run
	task automatic timeout_if(input int w);
		if (w >= 99)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	// entered at an edge; returns just after the taking edge
	task automatic issue(input logic [7:0] c, input logic [7:0] f, input logic [7:0] hi, input logic [7:0] lo);
		int w;
		cmd_i <= {c, f, hi, lo};
		cmd_valid_i <= 1'b1;
		#1;
		for (w = 0; cmd_ready_o !== 1'b1 && w < 99; w++)
		begin
			@(posedge ref_clk_i);
			#1;
		end
		timeout_if(w);
		@(posedge ref_clk_i);
		cmd_valid_i <= 1'b0;
		#1;
	endtask
	task automatic status(input stsr_attr_t a, input logic [15:0] sig);
		attr_i <= a;
		issue(STSR_CMD_MONITOR, STSR_FEAT_RET_STATUS, 8'h00, 8'h00);
		chk({cyl_load_o, cmd_abort_o, 6'h00}, 8'h80);
		chk({exceeded_o, 7'h00}, {sig == {STSR_BAD_CYL_HI, STSR_BAD_CYL_LO}, 7'h00});
		chk(cyl_hi_o, sig[15:8]);
		chk(cyl_lo_o, sig[7:0]);
		@(posedge ref_clk_i);
	endtask
	task automatic refuse(input logic [7:0] c, input logic [7:0] f, input logic [7:0] lo);
		issue(c, f, STSR_KEY_CYL_HI, lo);
		chk({cmd_abort_o, sec_valid_o, cyl_load_o, 5'h00}, 8'h80);
		@(posedge ref_clk_i);
	endtask
	function automatic logic [7:0] exp_b(input int i, input logic [7:0] s, input logic [7:0] e);
		logic [47:0] ids;
		ids = 48'hC4E5CBCCE8C7;
		if (i == 0)
			return 8'h04;
		if (i < 2 || i > 73 || (i - 2) % 12 > 1)
			return 8'h00;
		if ((i - 2) % 12 == 0)
			return ids[47 - 8 * ((i - 2) / 12) -: 8];
		return (i == 3) ? s : (i == 15) ? e : 8'h00;
	endfunction
	// thresholds flip after the take to prove they were latched
	task automatic sector(input logic [7:0] s, input logic [7:0] e, input logic stl);
		int i;
		int w;
		logic [7:0] x;
		logic [7:0] sum;
		sum = 8'h00;
		stall <= stl;
		attr_i <= {s, e, 16'h0000};
		issue(STSR_CMD_MONITOR, STSR_FEAT_READ_THR, STSR_KEY_CYL_HI, STSR_KEY_CYL_LO);
		for (i = 0; i < 512; i++)
		begin
			for (w = 0; !(sec_valid_o === 1'b1 && sec_ready_i === 1'b1) && w < 99; w++)
			begin
				@(posedge ref_clk_i);
				#1;
			end
			timeout_if(w);
			x = (i == 511) ? -sum : exp_b(i, s, e);
			sum += x;
			chk(sec_data_o, x);
			chk({sec_last_o, 7'h00}, {i == 511, 7'h00});
			@(posedge ref_clk_i);
			attr_i <= ~attr_i;
			#1;
		end
		chk({sec_done_o, sec_valid_o, cmd_ready_o, 5'h00}, 8'hA0);
		@(posedge ref_clk_i);
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		status(32'h1020_1020, 16'hC24F);
		status(32'h1020_0F20, 16'h2CF4);
		status(32'h1020_101F, 16'h2CF4);
		sector(8'h5A, 8'hA5, 1'b0);
		sector(8'hFF, 8'h01, 1'b1);
		refuse(STSR_CMD_MONITOR, STSR_FEAT_READ_THR, 8'h00);
		refuse(STSR_CMD_MONITOR, 8'hD0, STSR_KEY_CYL_LO);
		refuse(8'hEC, STSR_FEAT_READ_THR, STSR_KEY_CYL_LO);
		tally_and_finish();
	end
endmodule
`default_nettype wire
